/* hdl/ldc_regs.sv */
`default_nettype none
module ldc_regs #(
  parameter int unsigned FAULT_W = 32
) (
  input  wire logic               i_clk,
  input  wire logic               i_rst_n,
  input  wire logic               i_psel,
  input  wire logic               i_penable,
  input  wire logic               i_pwrite,
  input  wire logic [7:0]         i_paddr,
  input  wire logic [31:0]        i_pwdata,
  input  wire logic [FAULT_W-1:0] i_fault_status,
  output logic                    o_pready,
  output logic      [31:0]        o_prdata,
  output logic                    o_pslverr,
  output logic      [10:0]        o_red_open_mv,
  output logic      [10:0]        o_green_open_mv,
  output logic      [10:0]        o_blue_open_mv,
  output logic                    o_fault_readback_enable,
  output logic      [7:0]         o_red_colour_brightness,
  output logic      [7:0]         o_green_colour_brightness,
  output logic      [7:0]         o_blue_colour_brightness,
  output logic      [2:0]         o_global_brightness,
  output logic      [4:0]         o_short_removal_level,
  output logic      [11:0]        o_red_short_mv,
  output logic      [11:0]        o_green_short_mv,
  output logic      [11:0]        o_blue_short_mv,
  output logic      [4:0]         o_channel_current_ceiling_ma,
  output logic                    o_upper_scan_order_reverse,
  output logic      [47:0]        o_current_slew_and_coupling_config
);
  import ldc_pkg::*;

  // offsets below the colour supply, in mV
  function automatic logic [10:0] open_mv(input logic [1:0] code);
    case (code)
      2'h0:    open_mv = 11'h0C8;
      2'h1:    open_mv = 11'h1F4;
      2'h2:    open_mv = 11'h384;
      default: open_mv = 11'h4B0;
    endcase
  endfunction

  function automatic logic [11:0] short_gb_mv(input logic [2:0] code);
    case (code)
      3'h0:    short_gb_mv = 12'h0C8;
      3'h1:    short_gb_mv = 12'h190;
      3'h2:    short_gb_mv = 12'h320;
      3'h3:    short_gb_mv = 12'h4B0;
      3'h4:    short_gb_mv = 12'h640;
      3'h5:    short_gb_mv = 12'h7D0;
      3'h6:    short_gb_mv = 12'h960;
      default: short_gb_mv = 12'hAF0;
    endcase
  endfunction

  function automatic logic [11:0] short_r_mv(input logic [2:0] code);
    case (code)
      3'h0:    short_r_mv = 12'h0C8;
      3'h1:    short_r_mv = 12'h190;
      3'h2:    short_r_mv = 12'h320;
      3'h3:    short_r_mv = 12'h3E8;
      3'h4:    short_r_mv = 12'h4B0;
      3'h5:    short_r_mv = 12'h578;
      3'h6:    short_r_mv = 12'h640;
      default: short_r_mv = 12'h708;
    endcase
  endfunction

  logic        access;
  logic        commit;
  logic        ready_q;
  logic [31:0] rdata_q;
  logic        slverr_q;
  logic        wr_dbc;
  logic        wr_csc;
  logic [47:0] dbc;
  logic [47:0] csc;
  logic        mapped;
  logic [31:0] rdata_d;

  assign access = i_psel && i_penable;
  assign commit = access && ready_q;
  assign mapped = (i_paddr == ADDR_DBC_LO) || (i_paddr == ADDR_DBC_HI) || (i_paddr == ADDR_CSC_LO)
                  || (i_paddr == ADDR_CSC_HI) || (i_paddr == ADDR_FAULT);

  // one wait state, answer held until the master samples it
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= access && !ready_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      slverr_q <= 1'b0;
    end else begin
      slverr_q <= access && !ready_q && !mapped;
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    case (i_paddr)
      ADDR_DBC_LO: rdata_d = dbc[31:0];
      ADDR_DBC_HI: rdata_d = {16'h0000, dbc[47:32]};
      ADDR_CSC_LO: rdata_d = csc[31:0];
      ADDR_CSC_HI: rdata_d = {16'h0000, csc[47:32]};
      ADDR_FAULT:  rdata_d = o_fault_readback_enable ? 32'(i_fault_status) : 32'h0000_0000;
      default:     rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (access && !ready_q && !i_pwrite) begin
      rdata_q <= rdata_d;
    end
  end

  logic [31:0] dbc_stage_q;
  logic [31:0] csc_stage_q;

  // low word staged, high word commits the whole 48 bits
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      dbc_stage_q <= DBC_RST[31:0];
      csc_stage_q <= CSC_RST[31:0];
    end else if (commit && i_pwrite) begin
      if (i_paddr == ADDR_DBC_LO) begin
        dbc_stage_q <= i_pwdata;
      end
      if (i_paddr == ADDR_CSC_LO) begin
        csc_stage_q <= i_pwdata;
      end
    end
  end

  assign wr_dbc = commit && i_pwrite && (i_paddr == ADDR_DBC_HI);
  assign wr_csc = commit && i_pwrite && (i_paddr == ADDR_CSC_HI);

  ldc_cfg_word #(.RST(DBC_RST), .MASK(DBC_MASK)) u_detect_and_brightness_config (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_wr    (wr_dbc),
    .i_data  ({i_pwdata[15:0], dbc_stage_q}),
    .o_q     (dbc)
  );

  ldc_cfg_word #(.RST(CSC_RST), .MASK(CSC_MASK)) u_current_slew_and_coupling_config (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_wr    (wr_csc),
    .i_data  ({i_pwdata[15:0], csc_stage_q}),
    .o_q     (csc)
  );

  // decoded settings for the analog side
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_red_open_mv   <= open_mv(DBC_RST[RED_OPEN_LSB+:2]);
      o_green_open_mv <= open_mv(DBC_RST[GREEN_OPEN_LSB+:2]);
      o_blue_open_mv  <= open_mv(DBC_RST[BLUE_OPEN_LSB+:2]);
    end else begin
      o_red_open_mv   <= open_mv(dbc[RED_OPEN_LSB+:2]);
      o_green_open_mv <= open_mv(dbc[GREEN_OPEN_LSB+:2]);
      o_blue_open_mv  <= open_mv(dbc[BLUE_OPEN_LSB+:2]);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_fault_readback_enable <= DBC_RST[READBACK_BIT];
    end else begin
      o_fault_readback_enable <= dbc[READBACK_BIT];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_red_colour_brightness   <= DBC_RST[RED_BRT_LSB+:8];
      o_green_colour_brightness <= DBC_RST[GREEN_BRT_LSB+:8];
      o_blue_colour_brightness  <= DBC_RST[BLUE_BRT_LSB+:8];
      o_global_brightness       <= DBC_RST[GLOBAL_LSB+:3];
    end else begin
      o_red_colour_brightness   <= dbc[RED_BRT_LSB+:8];
      o_green_colour_brightness <= dbc[GREEN_BRT_LSB+:8];
      o_blue_colour_brightness  <= dbc[BLUE_BRT_LSB+:8];
      o_global_brightness       <= dbc[GLOBAL_LSB+:3];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_short_removal_level <= {1'b0, DBC_RST[REMOVAL_LSB+:4]} + 5'h01;
    end else begin
      o_short_removal_level <= {1'b0, dbc[REMOVAL_LSB+:4]} + 5'h01;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_red_short_mv   <= short_r_mv(DBC_RST[RED_SHORT_LSB+:3]);
      o_green_short_mv <= short_gb_mv(DBC_RST[GREEN_SHORT_LSB+:3]);
      o_blue_short_mv  <= short_gb_mv(DBC_RST[BLUE_SHORT_LSB+:3]);
    end else begin
      o_red_short_mv   <= short_r_mv(dbc[RED_SHORT_LSB+:3]);
      o_green_short_mv <= short_gb_mv(dbc[GREEN_SHORT_LSB+:3]);
      o_blue_short_mv  <= short_gb_mv(dbc[BLUE_SHORT_LSB+:3]);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_channel_current_ceiling_ma       <= CEIL_LOW_MA;
      o_upper_scan_order_reverse         <= CSC_RST[UPPER_SCAN_ORDER_REVERSE_BIT];
      o_current_slew_and_coupling_config <= CSC_RST & CSC_MASK;
    end else begin
      o_channel_current_ceiling_ma       <= csc[CEILING_BIT] ? CEIL_HIGH_MA : CEIL_LOW_MA;
      o_upper_scan_order_reverse         <= csc[UPPER_SCAN_ORDER_REVERSE_BIT];
      o_current_slew_and_coupling_config <= csc;
    end
  end

  assign o_pready  = ready_q;
  assign o_prdata  = rdata_q;
  assign o_pslverr = slverr_q;

  // checks
  logic past_ok_q;
  always_ff @(posedge i_clk) begin
    past_ok_q <= i_rst_n;
  end

  sequence s_hi_write_dbc;
    commit && i_pwrite && (i_paddr == ADDR_DBC_HI);
  endsequence

  property p_red_open;
    @(posedge i_clk) disable iff (!i_rst_n || !past_ok_q)
      s_hi_write_dbc ##1 1'b1 ##1 1'b1 |-> o_red_open_mv == open_mv($past(dbc_stage_q[1:0], 2));
  endproperty
  a_red_open: assert property (p_red_open) else $error("red open threshold wrong");

  property p_blue_open;
    @(posedge i_clk) disable iff (!i_rst_n || !past_ok_q)
      (dbc[5:4] == 2'h3) |=> (o_blue_open_mv == 11'h4B0);
  endproperty
  a_blue_open: assert property (p_blue_open) else $error("blue open threshold wrong");

  property p_readback_gate;
    @(posedge i_clk) disable iff (!i_rst_n)
      (access && !ready_q && !i_pwrite && (i_paddr == ADDR_FAULT) && !o_fault_readback_enable)
      |=> (o_prdata == 32'h0000_0000) && o_pready;
  endproperty
  a_readback_gate: assert property (p_readback_gate) else $error("fault readback not gated");

  property p_red_brt;
    @(posedge i_clk) disable iff (!i_rst_n || !past_ok_q)
      s_hi_write_dbc |-> ##2 o_red_colour_brightness == $past(dbc_stage_q[15:8], 2);
  endproperty
  a_red_brt: assert property (p_red_brt) else $error("red brightness not applied");

  property p_blue_brt;
    @(posedge i_clk) disable iff (!i_rst_n || !past_ok_q)
      s_hi_write_dbc |-> ##2 o_blue_colour_brightness == $past(dbc_stage_q[31:24], 2);
  endproperty
  a_blue_brt: assert property (p_blue_brt) else $error("blue brightness not applied");

  property p_global;
    @(posedge i_clk) disable iff (!i_rst_n || !past_ok_q)
      s_hi_write_dbc |-> ##2 o_global_brightness == $past(i_pwdata[2:0], 2);
  endproperty
  a_global: assert property (p_global) else $error("global brightness not applied");

  property p_removal;
    @(posedge i_clk) disable iff (!i_rst_n || !past_ok_q)
      s_hi_write_dbc |-> ##2 o_short_removal_level == {1'b0, $past(i_pwdata[6:3], 2)} + 5'h01;
  endproperty
  a_removal: assert property (p_removal) else $error("removal level not code plus one");

  property p_red_short;
    @(posedge i_clk) disable iff (!i_rst_n || !past_ok_q)
      (dbc[41:39] == 3'h3) |=> (o_red_short_mv == 12'h3E8);
  endproperty
  a_red_short: assert property (p_red_short) else $error("red short threshold wrong");

  property p_green_short;
    @(posedge i_clk) disable iff (!i_rst_n || !past_ok_q)
      (dbc[44:42] == 3'h7) |=> (o_green_short_mv == 12'hAF0);
  endproperty
  a_green_short: assert property (p_green_short) else $error("green short threshold wrong");

  property p_ceiling;
    @(posedge i_clk) disable iff (!i_rst_n || !past_ok_q)
      commit && i_pwrite && (i_paddr == ADDR_CSC_HI) |-> ##2
        o_channel_current_ceiling_ma == ($past(csc_stage_q[1], 2) ? 5'h14 : 5'h0A);
  endproperty
  a_ceiling: assert property (p_ceiling) else $error("current ceiling wrong");

  property p_upper_scan_order_reverse;
    @(posedge i_clk) disable iff (!i_rst_n || !past_ok_q)
      commit && i_pwrite && (i_paddr == ADDR_CSC_HI) |-> ##2
        o_upper_scan_order_reverse == $past(csc_stage_q[14], 2);
  endproperty
  a_upper_scan_order_reverse: assert property (p_upper_scan_order_reverse) else $error("scan reverse mismatch");

  property p_reserved;
    @(posedge i_clk) disable iff (!i_rst_n)
      ((dbc & ~DBC_MASK) == 48'h0) && ((csc & ~CSC_MASK) == 48'h0);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

  property p_atomic;
    @(posedge i_clk) disable iff (!i_rst_n || !past_ok_q)
      $changed(dbc) |-> $past(wr_dbc);
  endproperty
  a_atomic: assert property (p_atomic) else $error("register changed without high-word write");
endmodule // ldc_regs
`default_nettype wire

/* shared/ldc_pkg.sv */
// Overview of operation
// - red open-load threshold bits 1:0, reset 00b, 0.2/0.5/0.9/1.2 V below supply
// - green bits 3:2, blue bits 5:4, reset 00b, same open-load offset encoding
// - bit 7 enables readback of open and short detection results, reset 0
// - red colour brightness bits 15:8, linear 0 to 255, reset 127
// - green bits 23:16, blue bits 31:24, same brightness encoding, reset 127
// - global brightness bits 34:32, levels 0 to 7, reset 011b
// - short-removal field bits 38:35, code n gives level n+1, reset 0111b
// - red short threshold bits 41:39, reset 000b, 0.2 to 1.8 V steps
// - green 44:42, blue 47:45, reset 000b, 0.2 to 2.8 V steps
// - second register bit 1 picks 10 mA or 20 mA channel ceiling
// - second register bit 14 reverses upper scan lines, reset 1
`default_nettype none
package ldc_pkg;
  localparam int unsigned CFG_W = 48;
  // apb byte addresses
  localparam logic [7:0] ADDR_DBC_LO  = 8'h00;
  localparam logic [7:0] ADDR_DBC_HI  = 8'h04;
  localparam logic [7:0] ADDR_CSC_LO  = 8'h08;
  localparam logic [7:0] ADDR_CSC_HI  = 8'h0C;
  localparam logic [7:0] ADDR_FAULT   = 8'h10;
  // reset values and writable masks
  localparam logic [47:0] DBC_RST  = 48'h003B_7F7F_7F00;
  localparam logic [47:0] DBC_MASK = 48'hFFFF_FFFF_FFBF;
  localparam logic [47:0] CSC_RST  = 48'h0800_0540_4000;
  localparam logic [47:0] CSC_MASK = 48'h1FFF_0FFF_4002;
  // field positions
  localparam int unsigned RED_OPEN_LSB   = 0;
  localparam int unsigned GREEN_OPEN_LSB = 2;
  localparam int unsigned BLUE_OPEN_LSB  = 4;
  localparam int unsigned READBACK_BIT   = 7;
  localparam int unsigned RED_BRT_LSB    = 8;
  localparam int unsigned GREEN_BRT_LSB  = 16;
  localparam int unsigned BLUE_BRT_LSB   = 24;
  localparam int unsigned GLOBAL_LSB     = 32;
  localparam int unsigned REMOVAL_LSB    = 35;
  localparam int unsigned RED_SHORT_LSB  = 39;
  localparam int unsigned GREEN_SHORT_LSB= 42;
  localparam int unsigned BLUE_SHORT_LSB = 45;
  localparam int unsigned CEILING_BIT    = 1;
  localparam int unsigned UPPER_SCAN_ORDER_REVERSE_BIT   = 14;
  // ceilings in mA
  localparam logic [4:0] CEIL_LOW_MA  = 5'h0A;
  localparam logic [4:0] CEIL_HIGH_MA = 5'h14;
endpackage : ldc_pkg
`default_nettype wire

/* hdl/ldc_cfg_word.sv */
`default_nettype none
module ldc_cfg_word #(
  parameter logic [47:0] RST  = 48'h0,
  parameter logic [47:0] MASK = 48'h0
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_wr,
  input  wire logic [47:0] i_data,
  output logic      [47:0] o_q
);
  logic [47:0] word_q;

  // reserved positions stay at zero, writes to them are dropped
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      word_q <= RST & MASK;
    end else if (i_wr) begin
      word_q <= i_data & MASK;
    end
  end

  assign o_q = word_q;
endmodule // ldc_cfg_word
`default_nettype wire

/* dv/ldc_regs_test.sv */
`default_nettype none
module ldc_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ldc_pkg::*;

  typedef struct {logic rd; logic [31:0] data; logic err;} ldc_note_t;

  logic        i_clk;
  logic        i_rst_n;
  logic        i_psel;
  logic        i_penable;
  logic        i_pwrite;
  logic [7:0]  i_paddr;
  logic [31:0] i_pwdata;
  logic [31:0] i_fault_status;
  logic        o_pready;
  logic [31:0] o_prdata;
  logic        o_pslverr;
  logic [10:0] o_red_open_mv, o_green_open_mv, o_blue_open_mv;
  logic        o_fault_readback_enable;
  logic [7:0]  o_red_colour_brightness, o_green_colour_brightness, o_blue_colour_brightness;
  logic [2:0]  o_global_brightness;
  logic [4:0]  o_short_removal_level;
  logic [11:0] o_red_short_mv, o_green_short_mv, o_blue_short_mv;
  logic [4:0]  o_channel_current_ceiling_ma;
  logic        o_upper_scan_order_reverse;
  logic [47:0] o_current_slew_and_coupling_config;
  ldc_note_t   q[$];
  ldc_note_t   nt;
  int          err_total;
  int          checked;
  int          seed;
  logic [47:0] v;
  logic [47:0] c2;

  ldc_regs #(.FAULT_W(32)) u_dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_fault_status(i_fault_status), .o_pready(o_pready),
    .o_prdata(o_prdata), .o_pslverr(o_pslverr), .o_red_open_mv(o_red_open_mv),
    .o_green_open_mv(o_green_open_mv), .o_blue_open_mv(o_blue_open_mv),
    .o_fault_readback_enable(o_fault_readback_enable),
    .o_red_colour_brightness(o_red_colour_brightness),
    .o_green_colour_brightness(o_green_colour_brightness),
    .o_blue_colour_brightness(o_blue_colour_brightness), .o_global_brightness(o_global_brightness),
    .o_short_removal_level(o_short_removal_level), .o_red_short_mv(o_red_short_mv),
    .o_green_short_mv(o_green_short_mv), .o_blue_short_mv(o_blue_short_mv),
    .o_channel_current_ceiling_ma(o_channel_current_ceiling_ma),
    .o_upper_scan_order_reverse(o_upper_scan_order_reverse),
    .o_current_slew_and_coupling_config(o_current_slew_and_coupling_config)
  );

  task automatic check(input logic [47:0] seen, input logic [47:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // one transfer; caller stands just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e,
                     input logic er);
    int n;
    n = 0;
    q.push_back('{!wr, e, er});
    i_psel    <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite  <= wr;
    i_paddr   <= a;
    i_pwdata  <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 50);
    if (n >= 50) check(48'(o_pready), 48'h1, "no ready");
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic er = 1'b0);
    apb(1'b0, a, 32'h0, e, er);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic er = 1'b0);
    apb(1'b1, a, d, 32'h0, er);
  endtask

  task automatic idle;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clk);
  endtask

  // decoded outputs against both words
  task automatic dec(input logic [47:0] a, input logic [47:0] b);
    int unsigned op[4] = '{200, 500, 900, 1200};
    int unsigned rs[8] = '{200, 400, 800, 1000, 1200, 1400, 1600, 1800};
    int unsigned gs[8] = '{200, 400, 800, 1200, 1600, 2000, 2400, 2800};
    @(negedge i_clk);
    check(48'(o_red_open_mv), 48'(op[a[1:0]]), "red open");
    check(48'(o_green_open_mv), 48'(op[a[3:2]]), "green open");
    check(48'(o_blue_open_mv), 48'(op[a[5:4]]), "blue open");
    check(48'(o_fault_readback_enable), 48'(a[7]), "readback");
    check(48'(o_red_colour_brightness), 48'(a[15:8]), "red level");
    check(48'({o_blue_colour_brightness, o_green_colour_brightness}), 48'(a[31:16]), "gb level");
    check(48'(o_global_brightness), 48'(a[34:32]), "global");
    check(48'(o_short_removal_level), 48'(a[38:35]) + 48'h1, "removal");
    check(48'(o_red_short_mv), 48'(rs[a[41:39]]), "red short");
    check(48'(o_green_short_mv), 48'(gs[a[44:42]]), "green short");
    check(48'(o_blue_short_mv), 48'(gs[a[47:45]]), "blue short");
    check(48'(o_channel_current_ceiling_ma), b[1] ? 48'h14 : 48'h0A, "ceiling");
    check(48'(o_upper_scan_order_reverse), 48'(b[14]), "scan order");
    check(o_current_slew_and_coupling_config, b, "config copy");
    @(posedge i_clk);
  endtask

  always @(posedge i_clk) begin
    if (i_rst_n === 1'b1 && o_pready === 1'b1) begin
      if (q.size() == 0) begin
        check(48'(o_pready), 48'h0, "unexpected ready");
      end else begin
        nt = q.pop_front();
        if (nt.rd) check(48'(o_prdata), 48'(nt.data), "read data");
        check(48'(o_pslverr), 48'(nt.err), "slave error");
      end
    end
  end

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    err_total++;
    final_report();
  end

  initial begin
    seed = 70229;
    err_total = 0;
    checked = 0;
    i_rst_n = 1'b0;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 8'h00;
    i_pwdata = 32'h0;
    i_fault_status = 32'h0;
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    v = 48'h003B_7F7F_7F00;
    c2 = 48'h0800_0540_4000;
    dec(v, c2);
    rd(ADDR_DBC_LO, 32'h7F7F_7F00);
    rd(ADDR_DBC_HI, 32'h0000_003B);
    rd(ADDR_CSC_LO, 32'h0540_4000);
    rd(ADDR_CSC_HI, 32'h0000_0800);
    rd(ADDR_FAULT, 32'h0);
    rd(8'h14, 32'h0, 1'b1);
    wr(8'h14, 32'hFFFF_FFFF, 1'b1);
    idle();
    $display("test reset values done");
    for (int i = 0; i < 10; i++) begin
      v = (i == 0) ? 48'hFFFF_FFFF_FFFF : (i == 1) ? 48'h0 : (i == 2) ? 48'h0180_A5C3_5A3C
          : 48'({$random(seed), $random(seed)});
      i_fault_status <= $random(seed);
      wr(ADDR_DBC_LO, v[31:0]);
      wr(ADDR_DBC_HI, 32'(v[47:32]));
      idle();
      v = v & 48'hFFFF_FFFF_FFBF;
      dec(v, c2);
      wr(ADDR_DBC_LO, ~v[31:0]);
      rd(ADDR_DBC_LO, v[31:0]);
      rd(ADDR_DBC_HI, 32'(v[47:32]));
      rd(ADDR_FAULT, v[7] ? i_fault_status : 32'h0);
      idle();
    end
    $display("test first register done");
    for (int i = 0; i < 2; i++) begin
      c2 = (i == 0) ? 48'hFFFF_FFFF_FFFF : 48'h0;
      wr(ADDR_CSC_LO, c2[31:0]);
      wr(ADDR_CSC_HI, 32'(c2[47:32]));
      idle();
      c2 = c2 & 48'h1FFF_0FFF_4002;
      dec(v, c2);
      rd(ADDR_CSC_LO, c2[31:0]);
      rd(ADDR_CSC_HI, 32'(c2[47:32]));
      idle();
    end
    $display("test second register done");
    repeat (3) @(posedge i_clk);
    final_report();
  end
endmodule // ldc_regs_test
`default_nettype wire
